/* File: verilog/dtp_pixel_output.sv */
// Behaviour
// - external sync is the sole control input
// - level-controlled or programmable exposure mode selectable
// - one frame started per sync cycle
// - sync acts on edges, never levels
// - outputs stable for falling pixel clock sampling
// - pixel clock 40 MHz, 20 MHz when binning
// - frame valid high during whole frame
// - line valid high during whole line
// - data valid only with both qualifiers high
// - dual 10-bit: two pixels each cycle
// - dual 8-bit drops two sample LSBs
// - 10-bit odd pixel serializer bit map
// - 10-bit even pixel serializer bit map
// - 10-bit leaves inputs 9-12 unused
// - 8-bit odd pixel reuses odd map
// - 8-bit even pixel map, third port unused
// - qualifiers on 24/25, 23/26 unused
// - level mode: sync fall starts exposure
// - programmable mode: sync rise starts exposure
// - line gap 8.0 us, 15.5 us once
// - pixels sent ascending, two per cycle
`timescale 1ns/1ns
`default_nettype none
module dtp_pixel_output
  import dtp_pkg::*;
#(
  parameter logic [PAIR_W-1:0] PAIRS_PER_LINE = 10'h200,
  parameter logic [LINE_W-1:0] LINES_PER_FRAME = 11'h400
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic external_sync_in,
  input wire logic exp_mode_programmable,
  input wire logic cfg_depth8,
  input wire logic cfg_binning,
  output logic exposure_start,
  input wire logic link_clk,
  input wire logic [PIX_W-1:0] pix_odd,
  input wire logic [PIX_W-1:0] pix_even,
  output logic pixel_pair_take,
  output logic [SER_W-1:0] serializer_bit_input,
  output logic serializer_clock_input
);

  typedef struct packed {
    logic sync_prev;
    logic req_tog;
    logic exp_pulse;
  } dtp_sys_t;

  typedef struct packed {
    dtp_state_t st;
    logic div;
    logic bin;
    logic depth8;
    logic [CNT_W-1:0] cnt;
    logic [PAIR_W-1:0] pair;
    logic [LINE_W-1:0] line;
    logic req_seen;
    logic pend;
    logic long_gap;
    logic fval;
    logic lval;
    logic [SER_W-1:0] ser;
  } dtp_link_t;

  dtp_sys_t sys_q, sys_d;
  dtp_link_t lk_q, lk_d;
  logic sync_s;
  logic req_tog_s;
  logic rst_link;
  logic depth8_s;
  logic binning_s;
  logic take_c;

  // the sync pin comes from the grabber, asynchronous to sys_clk
  dtp_sync2 u_sync_pin (
    .clk(sys_clk),
    .d(external_sync_in),
    .q(sync_s)
  );

  // sys domain: edge detection and exposure start
  always_comb begin
    logic rise;
    logic fall;
    logic start;
    rise = 1'b0;
    fall = 1'b0;
    start = 1'b0;
    sys_d = sys_q;
    rise = sync_s & ~sys_q.sync_prev;
    fall = ~sync_s & sys_q.sync_prev;
    sys_d.sync_prev = sync_s;
    // mode picks which edge opens the exposure
    start = exp_mode_programmable ? rise : fall;
    sys_d.exp_pulse = start;
    // a toggle carries the frame request across, one per starting edge
    if (start) begin
      sys_d.req_tog = ~sys_q.req_tog;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sys_q <= '0;
    end else begin
      sys_q <= sys_d;
    end
  end

  assign exposure_start = sys_q.exp_pulse;

  // crossings into the link domain
  dtp_sync2 u_sync_rst (
    .clk(link_clk),
    .d(reset),
    .q(rst_link)
  );

  dtp_sync2 u_sync_req (
    .clk(link_clk),
    .d(sys_q.req_tog),
    .q(req_tog_s)
  );

  logic [1:0] cfg_raw;
  logic [1:0] cfg_s;
  assign cfg_raw = {cfg_binning, cfg_depth8};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cfg
      dtp_sync2 u_sync_cfg (
        .clk(link_clk),
        .d(cfg_raw[gi]),
        .q(cfg_s[gi])
      );
    end
  endgenerate

  assign depth8_s = cfg_s[0];
  assign binning_s = cfg_s[1];

  // serializer word: qualifiers always, pixels only while valid
  function automatic logic [SER_W-1:0] map_word(
    input logic fv,
    input logic lv,
    input logic d8,
    input logic [PIX_W-1:0] po,
    input logic [PIX_W-1:0] pe
  );
    logic [SER_W-1:0] w;
    logic [PIX8_W-1:0] o8;
    logic [PIX8_W-1:0] e8;
    w = '0;
    o8 = po[PIX_W-1:DROP_LSB];
    e8 = pe[PIX_W-1:DROP_LSB];
    w[LVAL_BIT] = lv;
    w[FVAL_BIT] = fv;
    // pixel bits left at zero outside valid cycles
    if (fv && lv) begin
      if (d8) begin
        for (int i = 0; i < PIX8_W; i++) begin
          w[ODD_MAP[i]] = o8[i];
          w[EVEN8_MAP[i]] = e8[i];
        end
      end else begin
        for (int i = 0; i < PIX_W; i++) begin
          w[ODD_MAP[i]] = po[i];
          w[EVEN10_MAP[i]] = pe[i];
        end
      end
    end
    return w;
  endfunction : map_word

  // link domain: frame and line sequencing
  always_comb begin
    logic step;
    logic [CNT_W-1:0] gap_len;
    step = 1'b0;
    gap_len = '0;
    lk_d = lk_q;
    take_c = 1'b0;
    lk_d.div = ~lk_q.div;
    // in binning the state moves only where the halved clock rises
    step = ~lk_q.bin | ~lk_q.div;
    if (lk_q.long_gap) begin
      gap_len = lk_q.bin ? CNT_W'(GAP_LONG_BIN_CYC - 1) : CNT_W'(GAP_LONG_CYC - 1);
    end else begin
      gap_len = lk_q.bin ? CNT_W'(GAP_BIN_CYC - 1) : CNT_W'(GAP_CYC - 1);
    end
    if (step) begin
      case (lk_q.st)
        DTP_IDLE: begin
          if (lk_q.pend) begin
            lk_d.pend = 1'b0;
            // configuration taken only here, never mid-frame
            lk_d.bin = binning_s;
            lk_d.depth8 = depth8_s;
            lk_d.fval = 1'b1;
            lk_d.line = '0;
            lk_d.cnt = binning_s ? CNT_W'(GAP_BIN_CYC - 1) : CNT_W'(GAP_CYC - 1);
            lk_d.st = DTP_LEAD;
          end
        end
        DTP_LEAD, DTP_GAP: begin
          if (lk_q.cnt == '0) begin
            lk_d.st = DTP_LINE;
            lk_d.lval = 1'b1;
            lk_d.pair = '0;
            take_c = 1'b1;
          end else begin
            lk_d.cnt = lk_q.cnt - 1'b1;
          end
        end
        DTP_LINE: begin
          if (lk_q.pair == PAIRS_PER_LINE - 1'b1) begin
            lk_d.lval = 1'b0;
            if (lk_q.line == LINES_PER_FRAME - 1'b1) begin
              lk_d.fval = 1'b0;
              lk_d.st = DTP_IDLE;
            end else begin
              lk_d.line = lk_q.line + 1'b1;
              lk_d.cnt = gap_len;
              lk_d.long_gap = 1'b0;
              lk_d.st = DTP_GAP;
            end
          end else begin
            lk_d.pair = lk_q.pair + 1'b1;
            take_c = 1'b1;
          end
        end
        default: begin
          lk_d.st = DTP_IDLE;
          lk_d.fval = 1'b0;
          lk_d.lval = 1'b0;
        end
      endcase
      lk_d.ser = map_word(lk_d.fval, lk_d.lval, lk_d.depth8, pix_odd, pix_even);
    end
    // request detection after the sequencer so a new request wins
    if (req_tog_s != lk_q.req_seen) begin
      lk_d.req_seen = req_tog_s;
      lk_d.pend = 1'b1;
      if (lk_q.fval) begin
        lk_d.long_gap = 1'b1;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (rst_link) begin
      lk_q <= '0;
      lk_q.req_seen <= 1'b0;
      lk_q.st <= DTP_IDLE;
    end else begin
      lk_q <= lk_d;
    end
  end

  // words change on the rising edge so the serializer sees them settled at the fall
  assign serializer_bit_input = lk_q.ser;
  // clock mux only switches between frames, when bin is reloaded
  assign serializer_clock_input = lk_q.bin ? lk_q.div : link_clk;
  assign pixel_pair_take = take_c;

endmodule : dtp_pixel_output
`default_nettype wire

/* File: verilog/dtp_pkg.sv */
`default_nettype none
package dtp_pkg;
  // link clock periods: 40 MHz normal, 20 MHz when binning
  localparam int LINK_PERIOD_NS = 25;
  localparam int LINK_PERIOD_BIN_NS = 50;
  // line valid low times
  localparam int GAP_NS = 8000;
  localparam int GAP_LONG_NS = 15500;
  localparam int GAP_CYC = (GAP_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int GAP_LONG_CYC = (GAP_LONG_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int GAP_BIN_CYC = (GAP_NS + LINK_PERIOD_BIN_NS - 1) / LINK_PERIOD_BIN_NS;
  localparam int GAP_LONG_BIN_CYC = (GAP_LONG_NS + LINK_PERIOD_BIN_NS - 1) / LINK_PERIOD_BIN_NS;
  localparam int CNT_W = 10;
  localparam int PAIR_W = 10;
  localparam int LINE_W = 11;
  localparam int SER_W = 28;
  localparam int PIX_W = 10;
  localparam int PIX8_W = 8;
  localparam int DROP_LSB = 2;
  // serializer input positions
  localparam int LVAL_BIT = 24;
  localparam int FVAL_BIT = 25;
  localparam int ODD_MAP [PIX_W] = '{0, 1, 2, 3, 4, 6, 27, 5, 7, 8};
  localparam int EVEN10_MAP [PIX_W] = '{15, 18, 19, 20, 21, 22, 16, 17, 13, 14};
  localparam int EVEN8_MAP [PIX8_W] = '{7, 8, 9, 12, 13, 14, 10, 11};
  typedef enum logic [1:0] {
    DTP_IDLE = 2'h0,
    DTP_LEAD = 2'h1,
    DTP_LINE = 2'h3,
    DTP_GAP = 2'h2
  } dtp_state_t;
endpackage : dtp_pkg
`default_nettype wire

/* File: verilog/dtp_sync2.sv */
`timescale 1ns/1ns
`default_nettype none
module dtp_sync2 (
  input wire logic clk,
  input wire logic d,
  output logic q
);
  logic meta_q;
  always_ff @(posedge clk) begin
    meta_q <= d;
    q <= meta_q;
  end
endmodule : dtp_sync2
`default_nettype wire

/* File: sim/dtp_pixel_output_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module dtp_chk
  import dtp_pkg::*;
#(parameter logic [PAIR_W-1:0] PAIRS_PER_LINE = 10'h200)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic external_sync_in,
  input wire logic exp_mode_programmable,
  input wire logic exposure_start,
  input wire logic link_clk,
  input wire logic pixel_pair_take,
  input wire logic [SER_W-1:0] serializer_bit_input
);
  wire logic [SER_W-1:0] w = serializer_bit_input;
  logic [LINE_W-1:0] run_q;
  // counts link cycles with line valid high; binning doubles it
  always_ff @(posedge link_clk) run_q <= w[24] ? run_q + 1'b1 : '0;
  logic [CNT_W-1:0] low_q;
  // link cycles inside a frame with line valid low; binning holds each step for two
  always_ff @(posedge link_clk) low_q <= (w[25] && !w[24]) ? low_q + 1'b1 : '0;
  chk_gap_len: assert property (@(posedge link_clk) disable iff (reset)
    $rose(w[24]) |-> low_q == GAP_CYC || low_q == GAP_LONG_CYC || low_q == 2 * GAP_BIN_CYC
      || low_q == 2 * GAP_LONG_BIN_CYC) else $error("line gap length");
  chk_fall_start: assert property (@(posedge sys_clk) disable iff (reset)
    !exp_mode_programmable && $fell(external_sync_in) |-> ##[1:4] exposure_start) else $error("no start on fall");
  chk_rise_start: assert property (@(posedge sys_clk) disable iff (reset)
    exp_mode_programmable && $rose(external_sync_in) |-> ##[1:4] exposure_start) else $error("no start on rise");
  chk_wrong_edge: assert property (@(posedge sys_clk) disable iff (reset)
    (exp_mode_programmable ? $fell(external_sync_in) : $rose(external_sync_in)) |=> !exposure_start [*4])
    else $error("start on wrong edge");
  chk_start_pulse: assert property (@(posedge sys_clk) disable iff (reset)
    exposure_start |=> !exposure_start) else $error("start pulse too long");
  chk_data_gated: assert property (@(posedge link_clk) disable iff (reset)
    !(w[24] && w[25]) |-> (w & ~28'h3000000) == '0) else $error("pixel bits outside line");
  chk_unused_zero: assert property (@(posedge link_clk) disable iff (reset)
    !w[23] && !w[26]) else $error("unused input driven");
  chk_take_line: assert property (@(posedge link_clk) disable iff (reset)
    pixel_pair_take |=> w[24] && w[25]) else $error("pair taken outside line");
  chk_line_len: assert property (@(posedge link_clk) disable iff (reset)
    $fell(w[24]) |-> run_q == PAIRS_PER_LINE || run_q == {PAIRS_PER_LINE, 1'b0}) else $error("line length");
endmodule : dtp_chk
`default_nettype wire

/* File: sim/dtp_grabber_model.sv */
`timescale 1ns/1ns
`default_nettype none
module dtp_grabber_model (
  input wire logic [27:0] w,
  input wire logic depth8,
  output logic pair_ok,
  output logic [27:0] pair
);
  // spare field on top must read zero: unused serializer inputs per mode
  assign pair_ok = w[24] & w[25];
  always_comb begin
    if (depth8) pair = {w[22:15], 2'h0, w[5], w[27], w[6], w[4:0], 2'h0, w[11], w[10], w[14:12], w[9:7]};
    else pair = {4'h0, w[12:9], w[8], w[7], w[5], w[27], w[6], w[4:0], w[14], w[13], w[17], w[16], w[22:18], w[15]};
  end
endmodule : dtp_grabber_model
`default_nettype wire

/* File: sim/dtp_pixel_output_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module dtp_pixel_output_bench;
  import dtp_pkg::*;
  localparam logic [2:0] MODES [4] = '{3'h0, 3'h5, 3'h2, 3'h1};
  logic sys_clk = 0, link_clk = 0, reset = 1, sync = 0, prog = 0, d8 = 0, bin = 0, took = 0, fv_d = 0;
  logic exp_start, take, ser_clk, pair_ok;
  logic [PIX_W-1:0] po = 10'h155, pe = 10'h2AA;
  logic [SER_W-1:0] word, got;
  logic [SER_W-1:0] exp_q [$];
  int err_count = 0, total_checks = 0, starts = 0, frames = 0;
  always #2 sys_clk = ~sys_clk;
  // odd offset keeps link edges off the system clock edges
  initial begin
    #5;
    forever #24 link_clk = ~link_clk;
  end
  dtp_pixel_output #(.PAIRS_PER_LINE(10'h004), .LINES_PER_FRAME(11'h002)) i_dtp_pixel_output (
    .sys_clk(sys_clk), .reset(reset), .external_sync_in(sync), .exp_mode_programmable(prog),
    .cfg_depth8(d8), .cfg_binning(bin), .exposure_start(exp_start), .link_clk(link_clk),
    .pix_odd(po), .pix_even(pe), .pixel_pair_take(take), .serializer_bit_input(word),
    .serializer_clock_input(ser_clk));
  dtp_grabber_model i_dtp_grabber_model (.w(word), .depth8(d8), .pair_ok(pair_ok), .pair(got));
  task automatic check(input logic [SER_W-1:0] g, input logic [SER_W-1:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check
  task automatic check_count(input int g, input int e);
    total_checks++;
    if (g != e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check_count
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic pulse;
    sync = 1;
    repeat (1000) @(negedge sys_clk);
    sync = 0;
  endtask : pulse
  task automatic wait_frames(input int n);
    for (int i = 0; i < 40000 && frames < n; i++) @(negedge sys_clk);
    if (frames < n) begin
      err_count++;
      conclude();
    end
  endtask : wait_frames
  always @(posedge link_clk) begin
    took <= take;
    if (take) exp_q.push_back(d8 ? {10'h0, po[9:2], 2'h0, pe[9:2]} : {8'h0, po, pe});
  end
  always @(negedge link_clk) begin
    if (took) begin
      po <= PIX_W'($urandom);
      pe <= PIX_W'($urandom);
    end
    if (fv_d && !word[25]) frames++;
    fv_d = word[25];
  end
  always @(negedge sys_clk) starts += int'(exp_start);
  always @(negedge ser_clk) begin
    if (!reset && pair_ok) check(got, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
  end
  initial begin
    void'($urandom(5));
    repeat (40) @(negedge sys_clk);
    reset = 0;
    repeat (60) @(negedge sys_clk);
    foreach (MODES[m]) begin
      {d8, bin, prog} = MODES[m];
      repeat (20) @(negedge sys_clk);
      pulse();
      if (m == 3) begin
        repeat (3000) @(negedge sys_clk);
        pulse();
      end
      wait_frames(m + 1 + int'(m == 3));
    end
    repeat (2000) @(negedge sys_clk);
    check_count(starts, 5);
    check_count(frames, 5);
    check_count(exp_q.size(), 0);
    conclude();
  end
endmodule : dtp_pixel_output_bench
bind dtp_pixel_output dtp_chk #(.PAIRS_PER_LINE(PAIRS_PER_LINE)) i_dtp_chk (.sys_clk(sys_clk), .reset(reset),
  .external_sync_in(external_sync_in), .exp_mode_programmable(exp_mode_programmable),
  .exposure_start(exposure_start), .link_clk(link_clk), .pixel_pair_take(pixel_pair_take),
  .serializer_bit_input(serializer_bit_input));
`default_nettype wire
